// [core/ddr_defines.svh]
// Purpose: Offsets, field positions, reset values and widths of the digital diagnostic results register
// Assumes: Included by its bare name from the package and the design files
// Notes:   Definitions only
`ifndef DDR_DEFINES_SVH
`define DDR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DDR_RESULTS_ADDR 5'h14
`define DDR_DAC_CONFIG_ADDR 5'h06

// ----------------------------------------------------------------------
// Field positions of the results word
// ----------------------------------------------------------------------
`define DDR_POS_FAULT_PIN 21
`define DDR_POS_ADDR_HI 20
`define DDR_POS_ADDR_LO 16
`define DDR_POS_UNREFRESHED 15
`define DDR_POS_SLEW_BUSY 14
`define DDR_POS_RESET_OCC 13
`define DDR_POS_WATCHDOG 11
`define DDR_POS_LATCH 8
`define DDR_POS_INVERSE 6

// ----------------------------------------------------------------------
// Widths, reset values and masks
// ----------------------------------------------------------------------
`define DDR_WORD_W 22
`define DDR_WDATA_W 16
`define DDR_RESET_VALUE 22'h14A000
`define DDR_RESERVED_MASK 22'h001680
`define DDR_RANGE_LSB 0
`define DDR_RANGE_W 4
`define DDR_RANGE_RESET 4'h0

`endif

// [core/ddr_pkg.sv]
// Purpose: Types shared by the digital diagnostic results block
// Assumes: Constants come from ddr_defines.svh
// Notes:   Types only
`include "ddr_defines.svh"

package ddr_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [`DDR_WORD_W-1:0] ddr_word_t;

  typedef enum logic [0:0] {
    DDR_RF_IDLE = 1'h0,
    DDR_RF_BUSY = 1'h1
  } ddr_refresh_state_t;

endpackage : ddr_pkg

// [core/ddr_sticky_flag.sv]
// Purpose: One sticky diagnostic flag that a host write of one re-evaluates
// Assumes: Condition and write strobe come from logic on clk
// Notes:   A condition in the update cycle keeps the flag set
`timescale 1ns/100ps
`default_nettype none

module ddr_sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Event and host update
  input wire logic cond,
  input wire logic update_w1,
  // Flag
  output logic flag_q
);

  logic flag_d;

  // Hold while set; a write of one reloads the present condition
  always_comb begin
    flag_d = flag_q | cond;
    if (update_w1) begin
      flag_d = cond; // Set wins over clear
    end
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : ddr_sticky_flag

`default_nettype wire

// [core/ddr_diag_results.sv]
// Purpose: Digital diagnostic results register with sticky flags and busy indicators
// Assumes: Register writes arrive decoded from the serial core on clk
// Notes:   The read image is registered every cycle on diag_rdata
//
// Overview of operation
// R1 - Sticky flags reload present condition on write-one
// R2 - Refresh and slew indicators clear by themselves
// R3 - Disabled diagnostic flags read back as zero
// R4 - Bit 15 unrefreshed, one after power-up
// R5 - Range change from idle starts refresh; any range change sets unrefreshed
// R6 - Bit 14 high while output slewing
// R7 - Bit 13 set by reset, write-one clears
// R8 - Bit 11 sticky watchdog fault
// R9 - Bit 8 sticky latch mismatch
// R10 - Bit 6 sticky inverse code mismatch
// R11 - Bit 21 live fault pin level
// R12 - Bits 20:16 hold address 0x14
// R13 - Host selects 0x14 then reads next frame
// R14 - Reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "ddr_defines.svh"

module ddr_diag_results #(
  parameter int CODE_W = 16,
  parameter logic [`DDR_RANGE_W-1:0] RANGE_RESET = `DDR_RANGE_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register writes from the serial core
  input wire logic reg_wr_strobe,
  input wire logic [4:0] reg_wr_addr,
  input wire logic [`DDR_WDATA_W-1:0] reg_wr_data,
  // Read image for readback
  output ddr_pkg::ddr_word_t diag_rdata,
  // Diagnostic enables from the configuration register
  input wire logic wdt_diag_en,
  input wire logic latch_mon_en,
  input wire logic inv_check_en,
  // Diagnostic sources
  input wire logic wdt_fault,
  input wire logic [CODE_W-1:0] latch_in_code,
  input wire logic [CODE_W-1:0] latch_out_code,
  input wire logic [CODE_W-1:0] dac_core_code,
  input wire logic [CODE_W-1:0] dac_code_inv,
  // Calibration memory refresh
  output logic refresh_start,
  input wire logic refresh_done,
  // Output slew and fault pin
  input wire logic slew_active,
  input wire logic fault_pin_level
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------

  localparam int NFLAG = 4;
  localparam int FLAG_POS [NFLAG] = '{`DDR_POS_WATCHDOG, `DDR_POS_LATCH,
                                      `DDR_POS_INVERSE, `DDR_POS_RESET_OCC};
  localparam logic [NFLAG-1:0] FLAG_RST = 4'h8;

  // Write strobe aimed at a given register
  function automatic logic reg_hit(input logic stb, input logic [4:0] addr,
                                   input logic [4:0] target);
    reg_hit = stb && (addr == target);
  endfunction : reg_hit

  logic results_wr;
  logic config_wr;
  logic [`DDR_RANGE_W-1:0] new_range;
  logic range_change;
  logic [`DDR_RANGE_W-1:0] range_q;
  logic [`DDR_RANGE_W-1:0] range_d;

  // Write decode for this register and the converter configuration
  assign results_wr = reg_hit(reg_wr_strobe, reg_wr_addr, `DDR_RESULTS_ADDR);
  assign config_wr = reg_hit(reg_wr_strobe, reg_wr_addr, `DDR_DAC_CONFIG_ADDR);
  assign new_range = reg_wr_data[`DDR_RANGE_LSB +: `DDR_RANGE_W];
  assign range_change = config_wr && (new_range != range_q); // R5

  // ----------------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------------

  logic [NFLAG-1:0] flag_cond;
  logic [NFLAG-1:0] flag_w1;
  logic [NFLAG-1:0] flag_q;

  // Present conditions of each diagnostic
  assign flag_cond[0] = wdt_fault; // R8
  assign flag_cond[1] = latch_in_code != latch_out_code; // R9
  assign flag_cond[2] = dac_core_code != ~dac_code_inv; // R10
  assign flag_cond[3] = 1'b0; // R7

  // One flag per diagnostic; reserved positions get no flag
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    assign flag_w1[i] = results_wr && reg_wr_data[FLAG_POS[i]]; // R1 R14
    ddr_sticky_flag #(
      .RESET_VAL(FLAG_RST[i])
    ) u_flag (
      .clk(clk),
      .reset(reset),
      .cond(flag_cond[i]),
      .update_w1(flag_w1[i]),
      .flag_q(flag_q[i])
    );
  end

  // Sticky flags hold, reload and clear as written
  chk_latch_hold: assert property ( // R1
    @(posedge clk) disable iff (reset)
    flag_q[1] && !flag_w1[1] |=> flag_q[1]
  ) else $error("latch mismatch flag lost without write");

  chk_inv_reload: assert property ( // R1
    @(posedge clk) disable iff (reset)
    flag_w1[2] |=> flag_q[2] == $past(flag_cond[2])
  ) else $error("inverse code flag not reloaded by write of one");

  chk_reset_clear: assert property ( // R7
    @(posedge clk) disable iff (reset)
    flag_w1[3] |=> !flag_q[3]
  ) else $error("reset occurred flag not cleared by write of one");

  // ----------------------------------------------------------------------
  // Calibration memory refresh tracking
  // ----------------------------------------------------------------------

  ddr_pkg::ddr_refresh_state_t rf_state_q;
  ddr_pkg::ddr_refresh_state_t rf_state_d;
  logic unrefreshed_q;
  logic unrefreshed_d;
  logic start_q;
  logic start_d;

  // Next state of refresh tracking and the shadow of the range field
  always_comb begin
    rf_state_d = rf_state_q;
    unrefreshed_d = unrefreshed_q;
    start_d = 1'b0;
    range_d = range_q;
    if (config_wr) begin
      range_d = new_range;
    end
    case (rf_state_q)
      ddr_pkg::DDR_RF_IDLE: begin
        if (range_change) begin
          rf_state_d = ddr_pkg::DDR_RF_BUSY;
          start_d = 1'b1; // R5
        end
      end
      ddr_pkg::DDR_RF_BUSY: begin
        if (refresh_done) begin
          rf_state_d = ddr_pkg::DDR_RF_IDLE;
        end
      end
      default: begin
        rf_state_d = ddr_pkg::DDR_RF_IDLE;
      end
    endcase
    if (range_change) begin
      unrefreshed_d = 1'b1; // R5
    end else if (refresh_done) begin
      unrefreshed_d = 1'b0; // R2
    end
  end

  // Refresh tracking registers
  always_ff @(posedge clk) begin
    if (reset) begin
      rf_state_q <= ddr_pkg::DDR_RF_IDLE;
      unrefreshed_q <= 1'b1; // R4
      start_q <= 1'b0;
      range_q <= RANGE_RESET;
    end else begin
      rf_state_q <= rf_state_d;
      unrefreshed_q <= unrefreshed_d;
      start_q <= start_d;
      range_q <= range_d;
    end
  end

  assign refresh_start = start_q;

  // Refresh starts only from idle, never while busy
  chk_range_pulse: assert property ( // R5
    @(posedge clk) disable iff (reset)
    range_change && rf_state_q == ddr_pkg::DDR_RF_IDLE |=> refresh_start
  ) else $error("range change from idle gave no refresh start");

  chk_busy_quiet: assert property ( // R5
    @(posedge clk) disable iff (reset)
    rf_state_q == ddr_pkg::DDR_RF_BUSY |=> !refresh_start
  ) else $error("refresh start issued while refresh busy");

  // ----------------------------------------------------------------------
  // Read image
  // ----------------------------------------------------------------------

  ddr_pkg::ddr_word_t img_d;
  ddr_pkg::ddr_word_t rdata_q;

  // Assemble the word; disabled diagnostics read zero
  always_comb begin
    img_d = '0; // R14
    img_d[`DDR_POS_FAULT_PIN] = fault_pin_level; // R11
    img_d[`DDR_POS_ADDR_HI:`DDR_POS_ADDR_LO] = `DDR_RESULTS_ADDR; // R12
    img_d[`DDR_POS_UNREFRESHED] = unrefreshed_q; // R4
    img_d[`DDR_POS_SLEW_BUSY] = slew_active; // R6 R2
    img_d[`DDR_POS_RESET_OCC] = flag_q[3]; // R7
    img_d[`DDR_POS_WATCHDOG] = flag_q[0] & wdt_diag_en; // R3
    img_d[`DDR_POS_LATCH] = flag_q[1] & latch_mon_en; // R3
    img_d[`DDR_POS_INVERSE] = flag_q[2] & inv_check_en; // R3
  end

  // Readback register
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= `DDR_RESET_VALUE;
    end else begin
      rdata_q <= img_d;
    end
  end

  assign diag_rdata = rdata_q;

  // Disabled watchdog and inverse flags read zero
  chk_wdt_masked: assert property ( // R3
    @(posedge clk) disable iff (reset)
    !$past(reset) && !$past(wdt_diag_en) |-> !rdata_q[`DDR_POS_WATCHDOG]
  ) else $error("disabled watchdog flag read as one");

  chk_inv_masked: assert property ( // R3
    @(posedge clk) disable iff (reset)
    !$past(reset) && !$past(inv_check_en) |-> !rdata_q[`DDR_POS_INVERSE]
  ) else $error("disabled inverse code flag read as one");

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  chk_w1_update: assert property ( // R1
    @(posedge clk) disable iff (reset)
    flag_w1[0] && !wdt_fault |=> !flag_q[0]
  ) else $error("watchdog flag not reloaded by write of one");

  chk_refresh_clear: assert property ( // R2
    @(posedge clk) disable iff (reset)
    refresh_done && !range_change |=> !unrefreshed_q ##1 !rdata_q[`DDR_POS_UNREFRESHED]
  ) else $error("unrefreshed indicator did not clear after refresh");

  chk_disabled_zero: assert property ( // R3
    @(posedge clk) disable iff (reset)
    !$past(reset) && !$past(latch_mon_en) |-> !rdata_q[`DDR_POS_LATCH]
  ) else $error("disabled latch monitor flag read as one");

  chk_unref_powerup: assert property ( // R4
    @(posedge clk) disable iff (reset)
    $fell(reset) |-> unrefreshed_q && rdata_q == `DDR_RESET_VALUE
  ) else $error("power-up readback wrong");

  chk_range_start: assert property ( // R5
    @(posedge clk) disable iff (reset)
    range_change |=> unrefreshed_q ##1 rdata_q[`DDR_POS_UNREFRESHED]
  ) else $error("range change did not mark memory unrefreshed");

  chk_slew_mirror: assert property ( // R6
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> rdata_q[`DDR_POS_SLEW_BUSY] == $past(slew_active)
  ) else $error("slew busy bit does not follow slewing");

  chk_reset_hold: assert property ( // R7
    @(posedge clk) disable iff (reset)
    flag_q[3] && !flag_w1[3] |=> flag_q[3]
  ) else $error("reset occurred flag lost without write");

  chk_wdt_sticky: assert property ( // R8
    @(posedge clk) disable iff (reset)
    wdt_fault ##1 wdt_diag_en |-> flag_q[0] ##1 rdata_q[`DDR_POS_WATCHDOG]
  ) else $error("watchdog fault not flagged");

  chk_latch_set: assert property ( // R9
    @(posedge clk) disable iff (reset)
    latch_in_code != latch_out_code |=> flag_q[1]
  ) else $error("latch mismatch not flagged");

  chk_inverse_set: assert property ( // R10
    @(posedge clk) disable iff (reset)
    dac_core_code != ~dac_code_inv |=> flag_q[2]
  ) else $error("inverse code mismatch not flagged");

  chk_pin_live: assert property ( // R11
    @(posedge clk) disable iff (reset)
    !$past(reset) |-> rdata_q[`DDR_POS_FAULT_PIN] == $past(fault_pin_level)
  ) else $error("fault pin bit not live");

  chk_addr_field: assert property ( // R12
    @(posedge clk) disable iff (reset)
    rdata_q[`DDR_POS_ADDR_HI:`DDR_POS_ADDR_LO] == `DDR_RESULTS_ADDR
  ) else $error("address field wrong");

  chk_reserved_zero: assert property ( // R14
    @(posedge clk) disable iff (reset)
    (rdata_q & `DDR_RESERVED_MASK) == '0
  ) else $error("reserved bit reads one");

endmodule : ddr_diag_results

`default_nettype wire

// [bench/ddr_refresh_model.sv]
// Purpose: Calibration memory refresh engine on the far side of the results register
// Assumes: Start pulse arrives on clk
// Notes:   Answers a fixed number of cycles after each start
`timescale 1ns/100ps
`default_nettype none

module ddr_refresh_model #(
  parameter int DELAY = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Refresh handshake
  input wire logic start,
  output logic done
);
  int cnt;

  // Count down from each start and pulse done once at the end
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 0;
      done <= 1'b0;
    end else begin
      done <= (cnt == 1);
      if (start) begin
        cnt <= DELAY;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : ddr_refresh_model

`default_nettype wire

// [bench/digital_diag_status_flags_bench.sv]
// Purpose: Self-checking bench for the digital diagnostic results register
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Read image is compared two edges after each write or input change, one edge after reset release and the busy range write
`timescale 1ns/100ps
`default_nettype none
`include "ddr_defines.svh"

module digital_diag_status_flags_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [21:0] BASE = 22'h140000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic strobe = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [2:0] en_v = 3'h7;
  logic [2:0] cond_v = 3'h0;
  logic [15:0] lin = 16'hA5C3;
  logic [15:0] core = 16'h3C5A;
  logic slew = 1'b0;
  logic fpin = 1'b0;
  logic refresh_start;
  logic refresh_done;
  ddr_pkg::ddr_word_t diag_rdata;
  int errors = 0;
  int total_checks = 0;
  int starts = 0;
  int pos[3] = '{`DDR_POS_WATCHDOG, `DDR_POS_LATCH, `DDR_POS_INVERSE};

  // ----------------------------------------------------------------
  // Design, refresh engine and clock
  // ----------------------------------------------------------------
  ddr_diag_results ddr_diag_results_i (
    .clk(clk), .reset(reset), .reg_wr_strobe(strobe), .reg_wr_addr(addr),
    .reg_wr_data(wdata), .diag_rdata(diag_rdata), .wdt_diag_en(en_v[0]),
    .latch_mon_en(en_v[1]), .inv_check_en(en_v[2]), .wdt_fault(cond_v[0]),
    .latch_in_code(lin), .latch_out_code(lin ^ 16'(cond_v[1])),
    .dac_core_code(core), .dac_code_inv(~core ^ 16'(cond_v[2])),
    .refresh_start(refresh_start), .refresh_done(refresh_done),
    .slew_active(slew), .fault_pin_level(fpin)
  );
  ddr_refresh_model ddr_refresh_model_i (
    .clk(clk), .reset(reset), .start(refresh_start), .done(refresh_done)
  );
  initial begin
    forever #25 clk = ~clk;
  end
  // Count refresh start pulses
  always @(posedge clk) begin
    if (refresh_start === 1'b1) starts++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    strobe = 1'b1;
    addr = a;
    wdata = d;
    tick(1);
    strobe = 1'b0;
  endtask : wr
  task automatic chk(input string name, input logic [21:0] exp);
    total_checks++;
    if (diag_rdata !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, diag_rdata);
    end
  endtask : chk
  task automatic chk_cnt(input string name, input int exp);
    total_checks++;
    if (starts != exp) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, starts);
    end
  endtask : chk_cnt
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    tick(1);
    chk("reset image", 22'h14A000);
    wr(5'h14, 16'h1680);
    tick(2);
    chk("reserved write", 22'h14A000);
    wr(5'h14, 16'h2000);
    tick(2);
    chk("reset flag clear", 22'h148000);
    $display("test reset and reserved done");
    wr(5'h06, 16'h0003);
    tick(2);
    chk("refresh pending", 22'h148000);
    tick(8);
    chk("refresh done", BASE);
    wr(5'h06, 16'h0003);
    tick(2);
    chk("same range", BASE);
    wr(5'h06, 16'h0005);
    tick(1);
    wr(5'h06, 16'h0007);
    tick(1);
    chk("busy range change", 22'h148000);
    tick(10);
    chk("refresh done again", BASE);
    chk_cnt("start pulses", 2);
    $display("test refresh done");
    for (int i = 0; i < 3; i++) begin
      cond_v[i] = 1'b1;
      tick(1);
      cond_v[i] = 1'b0;
      tick(2);
      chk("flag set", BASE | (22'h1 << pos[i]));
      en_v[i] = 1'b0;
      tick(2);
      chk("flag masked", BASE);
      en_v[i] = 1'b1;
      cond_v[i] = 1'b1;
      wr(5'h14, 16'h1 << pos[i]);
      tick(2);
      chk("flag held", BASE | (22'h1 << pos[i]));
      cond_v[i] = 1'b0;
      wr(5'h14, 16'h1 << pos[i]);
      tick(2);
      chk("flag cleared", BASE);
    end
    $display("test sticky flags done");
    fpin = 1'b1;
    slew = 1'b1;
    tick(2);
    chk("live bits high", 22'h344000);
    fpin = 1'b0;
    slew = 1'b0;
    tick(2);
    chk("live bits low", BASE);
    $display("test live bits done");
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    chk("second reset", 22'h14A000);
    wr(5'h06, 16'h0003);
    tick(2);
    chk_cnt("start after reset", 3);
    $display("test second reset done");
    summarize();
  end
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("[ERR] watchdog expired");
    summarize();
  end
endmodule : digital_diag_status_flags_bench

`default_nettype wire
